/* File: design/aisc_curve.sv */
`timescale 1ns/10ps
module aisc_curve #(
  parameter int DATA_W = aisc_pkg::AISC_DATA_W,
  parameter int NUM_PTS = aisc_pkg::AISC_NUM_PTS,
  parameter int NUM_SRC = aisc_pkg::AISC_NUM_SRC,
  parameter int SEL_W = aisc_pkg::AISC_SEL_W,
  parameter int UPD_W = aisc_pkg::AISC_UPD_W,
  parameter int TC_W = aisc_pkg::AISC_TC_W,
  parameter int STEP_CYC = aisc_pkg::AISC_STEP_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic channel_enable,
  input wire logic curve_enable,
  input wire logic [SEL_W-1:0] input_select,
  input wire logic [NUM_SRC-1:0][DATA_W-1:0] meas_data,
  input wire logic [NUM_SRC-1:0] meas_valid,
  input wire logic filter_enable,
  input wire logic [TC_W-1:0] filter_tc_steps,
  input wire logic [UPD_W-1:0] update_steps,
  input wire logic range_check_enable,
  input wire logic [DATA_W-1:0] input_min,
  input wire logic [DATA_W-1:0] input_max,
  input wire aisc_pkg::aisc_round_t value_handling,
  input wire logic [NUM_PTS-1:0][DATA_W-1:0] point_in,
  input wire logic [NUM_PTS-1:0][DATA_W-1:0] point_out,
  input wire logic [NUM_PTS-1:0] point_used,
  output logic [DATA_W-1:0] curve_input,
  output logic [DATA_W-1:0] curve_output,
  output logic scaling_curve_out_of_range,
  output logic curve_update_done
);
  import aisc_pkg::*;

  localparam int STEP_W = $clog2(STEP_CYC);
  localparam int WIDE = 2 * DATA_W + 2;

  // ****************************************
  // update cycle timer
  // ****************************************
  logic [STEP_W-1:0] step_cnt_q, step_cnt_d;
  logic [UPD_W-1:0] upd_cnt_q, upd_cnt_d;
  logic [UPD_W-1:0] upd_last;
  logic run;
  logic tick;

  assign run = channel_enable & curve_enable;
  // zero steps treated as one step
  assign upd_last = (update_steps == '0) ? '0 : update_steps - UPD_W'(1);

  always_comb begin
    step_cnt_d = step_cnt_q;
    upd_cnt_d = upd_cnt_q;
    tick = 1'b0;
    if (!run) begin
      step_cnt_d = '0;
      upd_cnt_d = '0;
    end else if (step_cnt_q == STEP_W'(STEP_CYC - 1)) begin
      step_cnt_d = '0;
      if (upd_cnt_q >= upd_last) begin
        upd_cnt_d = '0;
        tick = 1'b1;
      end else begin
        upd_cnt_d = upd_cnt_q + UPD_W'(1);
      end
    end else begin
      step_cnt_d = step_cnt_q + STEP_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      step_cnt_q <= '0;
      upd_cnt_q <= '0;
    end else begin
      step_cnt_q <= step_cnt_d;
      upd_cnt_q <= upd_cnt_d;
    end
  end

  // ****************************************
  // source select and input filter
  // ****************************************
  logic signed [DATA_W-1:0] filt_q, filt_d;
  logic have_q, have_d;
  logic calc_q, calc_d;
  logic [DATA_W-1:0] in_q, in_d;
  logic signed [DATA_W-1:0] x_sel;
  logic valid_sel;
  logic signed [WIDE-1:0] filt_step;

  assign valid_sel = (int'(input_select) < NUM_SRC) &&
                     meas_valid[input_select];
  assign x_sel = $signed(meas_data[input_select]);

  always_comb begin
    logic signed [WIDE-1:0] diff;
    logic signed [WIDE-1:0] den;
    diff = WIDE'(x_sel) - WIDE'(filt_q);
    den = WIDE'(update_steps) + WIDE'(filter_tc_steps);
    if (den == '0) begin
      den = WIDE'(1);
    end
    // first-order step: dt / (tau + dt)
    filt_step = (diff * $signed({1'b0, update_steps})) / den;
    filt_d = filt_q;
    have_d = have_q;
    in_d = in_q;
    calc_d = 1'b0;
    if (!run) begin
      filt_d = '0;
      have_d = 1'b0;
      in_d = AISC_ZERO;
    end else if (tick && valid_sel) begin
      if (filter_enable && have_q) begin
        filt_d = filt_q + DATA_W'(filt_step);
      end else begin
        filt_d = x_sel;
      end
      have_d = 1'b1;
      in_d = filt_d;
      calc_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      filt_q <= '0;
      have_q <= 1'b0;
      in_q <= '0;
      calc_q <= 1'b0;
    end else begin
      filt_q <= filt_d;
      have_q <= have_d;
      in_q <= in_d;
      calc_q <= calc_d;
    end
  end

  // ****************************************
  // curve, rounding and range check
  // ****************************************
  logic [DATA_W-1:0] out_q, out_d;
  logic range_q, range_d;
  logic done_q, done_d;
  logic signed [DATA_W-1:0] interp;
  logic signed [DATA_W-1:0] rounded;

  always_comb begin
    int lo;
    int hi;
    logic found_lo;
    logic found_hi;
    logic signed [DATA_W-1:0] x;
    logic signed [WIDE-1:0] num;
    logic signed [WIDE-1:0] span;
    lo = 0;
    hi = 0;
    found_lo = 1'b0;
    found_hi = 1'b0;
    x = $signed(in_q);
    // points one and two always take part
    for (int i = 0; i < NUM_PTS; i++) begin
      if (i < 2 || point_used[i]) begin
        if ($signed(point_in[i]) <= x && (!found_lo ||
            $signed(point_in[i]) > $signed(point_in[lo]))) begin
          lo = i;
          found_lo = 1'b1;
        end
        if ($signed(point_in[i]) > x && (!found_hi ||
            $signed(point_in[i]) < $signed(point_in[hi]))) begin
          hi = i;
          found_hi = 1'b1;
        end
      end
    end
    num = (WIDE'(x) - WIDE'($signed(point_in[lo]))) *
          (WIDE'($signed(point_out[hi])) - WIDE'($signed(point_out[lo])));
    span = WIDE'($signed(point_in[hi])) - WIDE'($signed(point_in[lo]));
    if (span == '0) begin
      span = WIDE'(1);
    end
    // outside the used points the end value is kept
    if (!found_lo) begin
      interp = $signed(point_out[hi]);
    end else if (!found_hi) begin
      interp = $signed(point_out[lo]);
    end else begin
      interp = $signed(point_out[lo]) + DATA_W'(num / span);
    end
  end

  always_comb begin
    logic signed [DATA_W-1:0] q;
    logic signed [DATA_W-1:0] r;
    logic signed [DATA_W-1:0] unit;
    unit = DATA_W'(AISC_UNIT);
    q = interp / unit;
    r = interp % unit;
    unique case (value_handling)
      AISC_FLOAT: rounded = interp;
      AISC_FLOOR: rounded = (r < 0) ? (q - 1) * unit : q * unit;
      AISC_CEIL: rounded = (r > 0) ? (q + 1) * unit : q * unit;
      AISC_NEAREST: begin
        // halves round away from zero
        if (2 * r >= unit) begin
          rounded = (q + 1) * unit;
        end else if (2 * r <= -unit) begin
          rounded = (q - 1) * unit;
        end else begin
          rounded = q * unit;
        end
      end
    endcase
  end

  always_comb begin
    out_d = out_q;
    range_d = range_q;
    done_d = 1'b0;
    if (!run) begin
      out_d = AISC_ZERO;
      range_d = 1'b0;
    end else if (calc_q) begin
      out_d = rounded;
      done_d = 1'b1;
      if (!range_check_enable) begin
        range_d = 1'b0;
      end else begin
        range_d = ($signed(in_q) < $signed(input_min)) ||
                  ($signed(in_q) > $signed(input_max));
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      out_q <= '0;
      range_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      out_q <= out_d;
      range_q <= range_d;
      done_q <= done_d;
    end
  end

  assign curve_input = in_q;
  assign curve_output = out_q;
  assign scaling_curve_out_of_range = range_q;
  assign curve_update_done = done_q;

endmodule

/* File: design/aisc_pkg.sv */
package aisc_pkg;

  // ****************************************
  // widths and fixed-point scale
  // ****************************************
  localparam int AISC_DATA_W = 48;
  localparam int AISC_NUM_PTS = 20;
  localparam int AISC_NUM_SRC = 16;
  localparam int AISC_SEL_W = 4;
  localparam int AISC_UPD_W = 11;
  localparam int AISC_TC_W = 20;
  // one unit of value in 0.00001 steps
  localparam longint AISC_UNIT = 100000;

  // ****************************************
  // timing
  // ****************************************
  localparam int AISC_CLK_HZ = 25000000;
  localparam int AISC_STEP_MS = 5;
  localparam int AISC_STEP_CYC = (AISC_CLK_HZ / 1000) * AISC_STEP_MS;
  localparam int AISC_UPD_DEF_MS = 150;
  localparam int AISC_UPD_DEF_STEPS = AISC_UPD_DEF_MS / AISC_STEP_MS;
  localparam int AISC_TC_DEF_MS = 1000;
  localparam int AISC_TC_DEF_STEPS = AISC_TC_DEF_MS / AISC_STEP_MS;

  // ****************************************
  // setting defaults, 0.00001 units
  // ****************************************
  localparam longint AISC_MIN_DEF = 0;
  localparam longint AISC_MAX_DEF = 0;
  localparam longint AISC_PT1_IN_DEF = 0;
  localparam longint AISC_PT2_IN_DEF = AISC_UNIT;
  localparam longint AISC_PT_OUT_DEF = 0;
  localparam logic [AISC_DATA_W-1:0] AISC_ZERO = 48'h0;

  typedef enum logic [1:0] {
    AISC_FLOAT,
    AISC_FLOOR,
    AISC_CEIL,
    AISC_NEAREST
  } aisc_round_t;

endpackage

/* File: sim/aisc_curve_monitor.sv */
`timescale 1ns/10ps
module aisc_curve_monitor #(
  parameter int DATA_W = 48
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic channel_enable,
  input wire logic curve_enable,
  input wire logic range_check_enable,
  input wire logic [DATA_W-1:0] input_min,
  input wire logic [DATA_W-1:0] input_max,
  input wire logic [DATA_W-1:0] curve_input,
  input wire logic [DATA_W-1:0] curve_output,
  input wire logic scaling_curve_out_of_range,
  input wire logic curve_update_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire run = channel_enable & curve_enable;
  wire oor = scaling_curve_out_of_range;
  wire done = curve_update_done;
  sequence s_pulse;
    done ##1 !done;
  endsequence
  // ****
  // update order
  // ****
  load_then_done_a: assert property ($changed(curve_input) && run &&
    $past(run) |=> s_pulse) else $error("no update after input");
  done_pulse_a: assert property (done |=> !done)
    else $error("done too long");
  run_off_a: assert property (!run |=> curve_input == '0 &&
    curve_output == '0 && !oor && !done) else $error("disabled active");
  hold_out_a: assert property ($changed(curve_output) || $changed(oor)
    |-> done || !$past(run)) else $error("output moved");
  // ****
  // range flag
  // ****
  range_off_a: assert property (done && !$past(range_check_enable)
    |-> !oor) else $error("flag while check off");
  range_low_a: assert property (done && $past(range_check_enable) &&
    $signed(curve_input) < $signed($past(input_min)) |-> oor)
    else $error("low not flagged");
  range_high_a: assert property (done && $past(range_check_enable) &&
    $signed(curve_input) > $signed($past(input_max)) |-> oor)
    else $error("high not flagged");
  range_in_a: assert property (done && oor |->
    $signed(curve_input) < $signed($past(input_min)) ||
    $signed(curve_input) > $signed($past(input_max)))
    else $error("false flag");
endmodule

/* File: sim/aisc_meas_model.sv */
`timescale 1ns/10ps
module aisc_meas_model (
  input wire logic clk,
  input wire logic ld,
  input wire logic [3:0] idx,
  input wire logic [aisc_pkg::AISC_DATA_W-1:0] val,
  input wire logic vld,
  output logic [15:0][aisc_pkg::AISC_DATA_W-1:0] md,
  output logic [15:0] mv
);
  import aisc_pkg::*;
  logic [15:0][AISC_DATA_W-1:0] held = '0;
  logic tgl = 1'b0;
  initial mv = '0;
  always @(posedge clk) begin
    tgl <= ~tgl;
    if (ld) begin
      held[idx] <= val;
      mv[idx] <= vld;
    end
  end
  // lost card: no stale value, flips each cycle
  always_comb for (int i = 0; i < 16; i++)
    md[i] = mv[i] ? held[i] : ~held[i] ^ {24{tgl, ~tgl}};
endmodule

/* File: sim/aisc_curve_tb_top.sv */
`timescale 1ns/10ps
module aisc_curve_tb_top;
  import aisc_pkg::*;
  localparam longint U = AISC_UNIT;
  localparam int STEP = 2;
  logic clk = 0, reset = 1, ch_en = 0, cv_en = 0, fen = 0, rce = 0;
  logic ld = 0, vld = 0, oor, done;
  logic [3:0] sel = 0, idx = 0;
  logic [10:0] upd = 4;
  logic [19:0] tc = 4, p_used = 0;
  logic [47:0] lo = 2 * U, hi = 8 * U, val = 0, c_in, c_out;
  logic [19:0][47:0] p_in = '0, p_out = '0;
  logic [15:0][47:0] md;
  logic [15:0] mv;
  logic [96:0] q[$];
  aisc_round_t hnd = AISC_FLOAT;
  int miscompares = 0, cmp_count = 0, seed = 76365;
  longint x, e;
  aisc_curve #(.STEP_CYC(STEP)) i_dut (.clk(clk), .reset(reset),
    .channel_enable(ch_en), .curve_enable(cv_en), .input_select(sel),
    .meas_data(md), .meas_valid(mv), .filter_enable(fen),
    .filter_tc_steps(tc), .update_steps(upd), .range_check_enable(rce),
    .input_min(lo), .input_max(hi), .value_handling(hnd),
    .point_in(p_in), .point_out(p_out), .point_used(p_used),
    .curve_input(c_in), .curve_output(c_out),
    .scaling_curve_out_of_range(oor), .curve_update_done(done));
  aisc_meas_model i_src (.clk(clk), .ld(ld), .idx(idx), .val(val),
    .vld(vld), .md(md), .mv(mv));
  always #20 clk = ~clk;
  // ****
  // checking
  // ****
  task automatic chk(input logic [96:0] s, e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (q.size() == 0) chk(1, 0);
      else chk({c_in, c_out, oor}, q.pop_front());
    end
  end
  function automatic longint rnd(longint v, int m);
    longint f;
    f = v / U * U;
    if (m == 1 && v < f) f -= U;
    if (m == 2 && v > f) f += U;
    if (m == 3) f = (v + (v < 0 ? -U / 2 : U / 2)) / U * U;
    return m == 0 ? v : f;
  endfunction
  // one sample; cy restarts the curve to time the first tick
  task automatic smp(input longint x, ei, eo, input logic ef, cy);
    int n;
    n = 0;
    @(negedge clk);
    cv_en = !cy;
    ld = 1;
    idx = sel;
    val = 48'(x);
    vld = 1;
    @(negedge clk);
    ld = 0;
    cv_en = 1;
    q.push_back({48'(ei), 48'(eo), ef});
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 99);
    if (cy) chk(n, STEP * upd + 1);
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
  // ****
  // scenarios
  // ****
  initial begin
    p_in[1] = 10 * U;
    p_out[1] = 50 * U;
    repeat (5) @(negedge clk);
    reset = 0;
    ch_en = 1;
    repeat (20) @(negedge clk);
    chk({c_in, c_out, oor}, 0);
    $display("end of disabled test");
    for (int i = 0; i < 6; i++) begin
      sel = 4'($random(seed));
      x = {$random(seed)} % (10 * U + 1);
      smp(x, x, 5 * x, 0, 1);
    end
    $display("end of random test");
    for (int m = 0; m < 8; m++) begin
      hnd = aisc_round_t'(m % 4);
      p_out[1] = m < 4 ? 50 * U : -50 * U;
      e = m < 4 ? 65 * U / 10 : -65 * U / 10;
      smp(13 * U / 10, 13 * U / 10, rnd(e, m % 4), 0, 1);
    end
    hnd = AISC_FLOAT;
    p_out[1] = 50 * U;
    $display("end of rounding test");
    for (int i = 0; i < 6; i++) begin
      x = i < 2 ? U : i == 2 ? 9 * U : i == 3 ? 5 * U : i == 4 ? 2 * U : 8 * U;
      rce = i != 0;
      smp(x, x, 5 * x, i == 1 || i == 2, 1);
    end
    rce = 0;
    $display("end of range test");
    fen = 1;
    smp(4 * U, 4 * U, 20 * U, 0, 1);
    smp(8 * U, 6 * U, 30 * U, 0, 0);
    smp(8 * U, 7 * U, 35 * U, 0, 0);
    fen = 0;
    $display("end of filter test");
    p_out[1] = -10000000 * U;
    smp(5 * U, 5 * U, -5000000 * U, 0, 1);
    p_out[1] = 50 * U;
    p_in[2] = 20 * U;
    p_out[2] = 80 * U;
    p_used[2] = 1;
    smp(15 * U, 15 * U, 65 * U, 0, 1);
    p_used[2] = 0;
    smp(15 * U, 15 * U, 50 * U, 0, 1);
    $display("end of points test");
    ld = 1;
    vld = 0;
    @(negedge clk);
    ld = 0;
    repeat (30) @(negedge clk);
    chk({c_in, c_out, oor}, {48'(15 * U), 48'(50 * U), 1'b0});
    ch_en = 0;
    repeat (2) @(negedge clk);
    chk({c_in, c_out, oor}, 0);
    chk(q.size(), 0);
    $display("end of loss test");
    print_verdict;
  end
endmodule
bind aisc_curve aisc_curve_monitor #(.DATA_W(DATA_W)) u_mon (.clk(clk),
  .reset(reset), .channel_enable(channel_enable),
  .curve_enable(curve_enable), .range_check_enable(range_check_enable),
  .input_min(input_min), .input_max(input_max),
  .curve_input(curve_input), .curve_output(curve_output),
  .scaling_curve_out_of_range(scaling_curve_out_of_range),
  .curve_update_done(curve_update_done));
